/* File: shared/sas_pkg.sv */
`default_nettype none
package sas_pkg;
  localparam int RES_W = 10;
  localparam int CONV_TADS = 11;
  localparam int ABORT_TADS = 2;
  localparam int INSTR_CYCLES_DFLT = 4;
  localparam int ADR_W = 8;
  // Register word indices, byte address is index * 4
  localparam logic [5:0] IDX_CTRL = 6'h1F;
  localparam logic [5:0] IDX_ANALOG_SELECT_REG = 6'h20;
  localparam logic [5:0] IDX_RESH = 6'h21;
  localparam logic [5:0] IDX_RESL = 6'h22;
  localparam logic [5:0] IDX_FLAG = 6'h23;
  localparam logic [5:0] IDX_MASK = 6'h24;
  localparam logic [5:0] IDX_DIR = 6'h25;
  // converter_control fields
  localparam int CTRL_ON = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_CHS = 2;
  localparam int CTRL_VREF = 6;
  localparam int CTRL_JUST = 7;
  // analog_select_reg fields
  localparam int ANALOG_SELECT_REG_CS = 4;
  localparam logic [3:0] ANS_RST = 4'hF;
  localparam logic [3:0] DIR_RST = 4'hF;
  // peripheral_flag_reg and mask
  localparam int FLAG_DONE = 6;
  // conv_clock_select codes
  localparam logic [2:0] CS_DIV2 = 3'b000;
  localparam logic [2:0] CS_DIV4 = 3'b100;
  localparam logic [2:0] CS_DIV8 = 3'b001;
  localparam logic [2:0] CS_DIV16 = 3'b101;
  localparam logic [2:0] CS_DIV32 = 3'b010;
  localparam logic [2:0] CS_DIV64 = 3'b110;
  localparam logic [1:0] CS_RC_LO = 2'b11;
endpackage
`default_nettype wire

/* File: design/sas_sar_core.sv */
`timescale 1ns/1ps
`default_nettype none
module sas_sar_core #(
  parameter int CODE_W = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic step,
  input wire logic comp,
  output logic busy,
  output logic done,
  output logic [CODE_W-1:0] code
);
  import sas_pkg::*;

  if (CODE_W < 2 || CODE_W > 14) begin : g_chk
    $error("CODE_W must be 2 to 14");
  end

  localparam logic [3:0] LAST = 4'(CODE_W);

  typedef struct packed {
    logic busy;
    logic done;
    logic [3:0] cnt;
    logic [CODE_W-1:0] code;
  } sas_core_s;

  sas_core_s q, d;
  logic [3:0] idx;
  logic [CODE_W-1:0] t;

  always_comb begin
    d = q;
    d.done = 1'b0;
    idx = LAST - q.cnt;
    t = q.code;
    if (abort) begin
      d.busy = 1'b0;
    end else if (start) begin
      d.busy = 1'b1;
      d.cnt = 4'h0;
      d.code = '0;
      d.code[CODE_W-1] = 1'b1;
    end else if (q.busy && step) begin
      // First period holds the sample, then one bit per period
      if (q.cnt != 4'h0) begin
        t[idx] = comp;
        if (idx != 4'h0) begin
          t[idx-4'h1] = 1'b1;
        end
        d.code = t;
      end
      if (q.cnt == LAST) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end
    if (rst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign busy = q.busy;
  assign done = q.done;
  assign code = q.code;

  // Periods counted independently of the core counter
  logic [4:0] nsteps_q;
  always_ff @(posedge clk) begin
    if (rst || start) begin
      nsteps_q <= 5'h00;
    end else if (q.busy && step) begin
      nsteps_q <= nsteps_q + 5'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_ELEVEN_TADS: assert property (q.done |-> nsteps_q == 5'(CONV_TADS))
    else $error("conversion did not take eleven periods");
  AST_BUSY_UNTIL_DONE: assert property ($fell(q.busy) |-> q.done || $past(abort) || $past(rst))
    else $error("busy dropped without done or abort");
endmodule // sas_sar_core
`default_nettype wire

/* File: design/sas_adc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Successive approximation yields a 10-bit result kept in a result pair.
// - Two-bit channel field routes one of four inputs to sample-and-hold.
// - Control bit 6 picks external reference pin when set, supply when clear.
// - Every conversion lasts eleven conversion-clock periods.
// - Three-bit field picks oscillator divide 2 to 64, or RC clock.
// - Writing 1 to control bits 1 and 0 while already on starts conversion on selected channel.
// - Completion clears start bit, sets done flag bit 6, raises interrupt when mask bit 6 is set.
// - Clearing start bit mid-conversion aborts; result keeps previous value.
// - After abort wait two periods, then acquire on selected channel.
// - Control bit 7 set gives right-justified, clear gives left-justified result.
// - Analog-select bits disable pin input buffers; direction bits tristate drivers.
// - Reset turns module off, aborts conversion, leaves result pair unchanged.
// - With RC clock, wait one instruction cycle before conversion begins.
module sas_adc_top #(
  parameter int INSTR_CYCLES = sas_pkg::INSTR_CYCLES_DFLT
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [sas_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ,
  input wire logic COMP_IN,
  input wire logic RC_OSC_IN,
  output logic CONV_ENABLE,
  output logic SAMPLE_HOLD,
  output logic [1:0] CHANNEL_SELECT,
  output logic REF_EXTERNAL,
  output logic [sas_pkg::RES_W-1:0] DAC_CODE,
  output logic [3:0] DIG_IN_DISABLE,
  output logic [3:0] PIN_TRISTATE
);
  import sas_pkg::*;

  if (INSTR_CYCLES < 1 || INSTR_CYCLES > 255) begin : g_chk
    $error("INSTR_CYCLES must be 1 to 255");
  end

  localparam logic [7:0] WAIT_LAST = 8'(INSTR_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_ACQ,
    ST_RCW,
    ST_CONV,
    ST_ABORT
  } sas_state_e;

  typedef struct packed {
    sas_state_e st;
    logic on;
    logic go;
    logic [1:0] chs;
    logic vref;
    logic just;
    logic [2:0] cs;
    logic [3:0] ans;
    logic [3:0] dir;
    logic [RES_W-1:0] result;
    logic flag;
    logic mask;
    logic [5:0] div;
    logic abt;
    logic [7:0] wcnt;
    logic ack;
    logic [7:0] dat;
    logic cs1;
    logic cs2;
    logic rs1;
    logic rs2;
    logic rs3;
  } sas_top_s;

  sas_top_s q, d;
  logic wr;
  logic rc_sel;
  logic conv_clock_period;
  logic [5:0] div_last;
  logic core_start;
  logic core_abort;
  logic core_busy;
  logic core_done;
  logic [RES_W-1:0] core_code;
  logic [5:0] idx;
  logic [7:0] resh;
  logic [7:0] resl;
  logic [7:0] rbyte;
  logic [7:0] wd;

  assign idx = WB_ADR_I[7:2];
  assign wd = WB_DAT_I[7:0];
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & q.ack & WB_SEL_I[0];
  assign rc_sel = (q.cs[1:0] == CS_RC_LO);

  // Divider ratio per clock setting
  always_comb begin
    case (q.cs)
      CS_DIV2: div_last = 6'h01;
      CS_DIV4: div_last = 6'h03;
      CS_DIV8: div_last = 6'h07;
      CS_DIV16: div_last = 6'h0F;
      CS_DIV32: div_last = 6'h1F;
      CS_DIV64: div_last = 6'h3F;
      default: div_last = 6'h01;
    endcase
  end

  // RC clock edges come through the synchroniser
  assign conv_clock_period = rc_sel ? (q.rs2 & ~q.rs3) : (q.div == div_last);

  // Result layout by justification
  assign resh = q.just ? {6'h00, q.result[9:8]} : q.result[9:2];
  assign resl = q.just ? q.result[7:0] : {q.result[1:0], 6'h00};

  always_comb begin
    case (idx)
      IDX_CTRL: rbyte = {q.just, q.vref, 2'b00, q.chs, q.go, q.on};
      IDX_ANALOG_SELECT_REG: rbyte = {1'b0, q.cs, q.ans};
      IDX_RESH: rbyte = resh;
      IDX_RESL: rbyte = resl;
      IDX_FLAG: rbyte = 8'(q.flag) << FLAG_DONE;
      IDX_MASK: rbyte = 8'(q.mask) << FLAG_DONE;
      IDX_DIR: rbyte = {4'h0, q.dir};
      default: rbyte = 8'h00;
    endcase
  end

  always_comb begin
    d = q;
    core_start = 1'b0;
    core_abort = 1'b0;
    d.cs1 = COMP_IN;
    d.cs2 = q.cs1;
    d.rs1 = RC_OSC_IN;
    d.rs2 = q.rs1;
    d.rs3 = q.rs2;
    d.ack = WB_CYC_I & WB_STB_I & ~q.ack;
    if (WB_CYC_I & WB_STB_I & ~q.ack) begin
      d.dat = rbyte;
    end
    if (wr) begin
      case (idx)
        IDX_CTRL: begin
          d.on = wd[CTRL_ON];
          // Start accepted only when already on
          d.go = wd[CTRL_GO] & q.on & wd[CTRL_ON];
          d.chs = wd[CTRL_CHS+:2];
          d.vref = wd[CTRL_VREF];
          d.just = wd[CTRL_JUST];
        end
        IDX_ANALOG_SELECT_REG: begin
          d.cs = wd[ANALOG_SELECT_REG_CS+:3];
          d.ans = wd[3:0];
        end
        IDX_FLAG: d.flag = q.flag & ~wd[FLAG_DONE];
        IDX_MASK: d.mask = wd[FLAG_DONE];
        IDX_DIR: d.dir = wd[3:0];
        default: begin
        end
      endcase
    end
    d.div = (q.st == ST_ACQ || q.st == ST_RCW || conv_clock_period) ? 6'h00 : q.div + 6'h01;
    case (q.st)
      ST_ACQ: begin
        if (q.go && q.on) begin
          if (rc_sel) begin
            d.st = ST_RCW;
            d.wcnt = 8'h00;
          end else begin
            d.st = ST_CONV;
            core_start = 1'b1;
          end
        end
      end
      ST_RCW: begin
        if (!q.go || !q.on) begin
          d.st = ST_ACQ;
        end else if (q.wcnt == WAIT_LAST) begin
          d.st = ST_CONV;
          core_start = 1'b1;
        end else begin
          d.wcnt = q.wcnt + 8'h01;
        end
      end
      ST_CONV: begin
        if (!q.on) begin
          core_abort = 1'b1;
          d.st = ST_ACQ;
        end else if (!q.go) begin
          core_abort = 1'b1;
          d.div = 6'h00; // Hold-off counts whole periods
          d.st = ST_ABORT;
          d.abt = 1'b0;
        end else if (core_done) begin
          d.result = core_code;
          d.go = 1'b0;
          d.flag = 1'b1;
          d.st = ST_ACQ;
        end
      end
      ST_ABORT: begin
        if (!q.on) begin
          d.st = ST_ACQ;
        end else if (conv_clock_period) begin
          // Second period ends the hold-off, acquisition resumes
          if (q.abt) begin
            d.st = ST_ACQ;
          end else begin
            d.abt = 1'b1;
          end
        end
      end
      default: d.st = ST_ACQ;
    endcase
    if (RST) begin
      d = '0;
      d.st = ST_ACQ;
      d.ans = ANS_RST;
      d.dir = DIR_RST;
      d.result = q.result;
      core_abort = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    q <= d;
  end

  sas_sar_core #(
    .CODE_W(RES_W)
  ) u_core (
    .clk(CORE_CLK),
    .rst(RST),
    .start(core_start),
    .abort(core_abort),
    .step(conv_clock_period),
    .comp(q.cs2),
    .busy(core_busy),
    .done(core_done),
    .code(core_code)
  );

  assign WB_DAT_O = {24'h0000_00, q.dat};
  assign WB_ACK_O = q.ack;
  assign IRQ = q.flag & q.mask;
  assign CONV_ENABLE = q.on;
  assign SAMPLE_HOLD = q.on & (q.st == ST_ACQ || q.st == ST_RCW);
  assign CHANNEL_SELECT = q.chs;
  assign REF_EXTERNAL = q.vref;
  assign DAC_CODE = core_code;
  assign DIG_IN_DISABLE = q.ans;
  assign PIN_TRISTATE = q.dir;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  AST_RESULT_LOAD: assert property (q.st == ST_CONV && q.on && q.go && core_done |=> q.result == $past(core_code))
    else $error("result not loaded on completion");
  AST_CHAN_ROUTE: assert property (wr && idx == IDX_CTRL |=> CHANNEL_SELECT == $past(WB_DAT_I[3:2]))
    else $error("channel select not applied");
  AST_REF_SEL: assert property (wr && idx == IDX_CTRL |=> REF_EXTERNAL == $past(WB_DAT_I[6]))
    else $error("reference select not applied");
  AST_GO_START: assert property (wr && idx == IDX_CTRL && wd[1:0] == 2'b11 && q.on && q.st == ST_ACQ && !rc_sel
    |-> ##2 core_busy)
    else $error("start did not launch conversion");
  AST_DONE_FLAG: assert property (q.st == ST_CONV && q.on && q.go && core_done |=> q.flag && !q.go && IRQ == q.mask)
    else $error("completion did not set flag and clear start");
  AST_ABORT_KEEP: assert property (q.st == ST_CONV && q.on && !q.go |=> q.st == ST_ABORT && $stable(q.result))
    else $error("abort lost or result changed");
  AST_ABORT_HOLD: assert property (q.st == ST_ABORT && q.on && !(conv_clock_period && q.abt) |=> q.st == ST_ABORT)
    else $error("acquisition during abort hold-off");
  AST_ABORT_END: assert property (q.st == ST_ABORT && q.on && conv_clock_period && q.abt |=> SAMPLE_HOLD)
    else $error("acquisition did not resume after abort");
  AST_JUSTIFY: assert property (q.just ? ({resh[1:0], resl} === q.result && resh[7:2] == 6'h00)
    : ({resh, resl[7:6]} === q.result && resl[5:0] == 6'h00))
    else $error("result justification wrong");
  AST_RC_WAIT: assert property (q.st == ST_ACQ && q.go && q.on && rc_sel |=> !core_busy [*2])
    else $error("RC conversion started without wait");
  AST_OFF_IGNORES: assert property (!q.on |=> !q.go)
    else $error("start accepted while off");
  AST_RSVD_ZERO: assert property (WB_ACK_O && !WB_WE_I && idx == IDX_CTRL |-> WB_DAT_O[5:4] == 2'b00)
    else $error("reserved control bits read nonzero");
  AST_RESET_OFF: assert property (@(posedge CORE_CLK) disable iff (1'b0)
    RST |=> !CONV_ENABLE && q.st == ST_ACQ && q.result === $past(q.result))
    else $error("reset did not switch off or altered result");

  COV_DONE: cover property (q.st == ST_CONV && core_done && q.go);
  COV_ABORT: cover property (q.st == ST_ABORT && conv_clock_period && q.abt);
  COV_RC: cover property (q.st == ST_RCW ##1 q.st == ST_CONV);
endmodule // sas_adc_top
`default_nettype wire

/* File: testbench/sas_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model #(
  parameter logic [9:0] LVL [4] = '{10'h155, 10'h2AA, 10'h3FF, 10'h001}
) (
  input wire logic [1:0] channel_select,
  input wire logic ref_external,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  output logic comp_in,
  output logic rc_osc_in
);
  logic [9:0] held;
  initial begin
    rc_osc_in = 1'b0;
    held = 10'h000;
  end
  // Free-running RC oscillator, 2 us period, above the minimum
  always #1000 rc_osc_in = ~rc_osc_in;
  // Track while sampling, hold during conversion; external ref halves the code
  always @(*) begin
    if (sample_hold) begin
      held = ref_external ? (LVL[channel_select] >> 1) : LVL[channel_select];
    end
  end
  assign comp_in = (held >= dac_code);
endmodule // sas_analog_model
`default_nettype wire

/* File: testbench/sar_adc_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_bench;
  import sas_pkg::*;
  localparam logic [9:0] LVL [4] = '{10'h155, 10'h2AA, 10'h3FF, 10'h001};
  logic clk, rst, cyc, stb, we, comp, rc, irq, ack, on, sh, rext;
  logic [7:0] adr;
  logic [31:0] dat, dat_o, v;
  logic [1:0] chs;
  logic [9:0] dac;
  logic [3:0] did, tri_s;
  logic msk;
  logic [7:0] ph, pl;
  int err_total, num_checks, low_n, last_low;
  logic [2:0] cs_tab [6] = '{CS_DIV2, CS_DIV4, CS_DIV8, CS_DIV16, CS_DIV32, CS_DIV64};
  sas_adc_top #(.INSTR_CYCLES(2)) DUT (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .IRQ(irq), .COMP_IN(comp), .RC_OSC_IN(rc), .CONV_ENABLE(on), .SAMPLE_HOLD(sh),
    .CHANNEL_SELECT(chs), .REF_EXTERNAL(rext), .DAC_CODE(dac), .DIG_IN_DISABLE(did),
    .PIN_TRISTATE(tri_s));
  sas_analog_model #(.LVL(LVL)) model (.channel_select(chs), .ref_external(rext), .sample_hold(sh),
    .dac_code(dac), .comp_in(comp), .rc_osc_in(rc));
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // Length of each low stretch of the sample line while enabled
  always @(posedge clk) begin
    if (!sh && on) begin
      low_n <= low_n + 1;
    end else begin
      if (low_n != 0) last_low <= low_n;
      low_n <= 0;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h00_0000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n == 50) err_total++;
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb(idx, 1'b1, d, v);
  endtask
  task automatic chk_reg(input logic [5:0] idx, input logic [7:0] e);
    wb(idx, 1'b0, 8'h00, v);
    chk($sformatf("reg %h", idx), {24'h00_0000, e}, v);
  endtask
  task automatic convert(input logic [2:0] cs, input int ch, input logic jr, input logic vr, input int div);
    logic [7:0] c;
    logic [9:0] r;
    int n;
    c = {jr, vr, 2'b00, ch[1:0], 2'b01};
    wr(IDX_ANALOG_SELECT_REG, {1'b0, cs, 4'hF});
    wr(IDX_CTRL, c);
    wr(IDX_CTRL, c | 8'h02);
    n = 0;
    v = 32'h0000_0002;
    while (v[1] !== 1'b0 && n < 400) begin
      wb(IDX_CTRL, 1'b0, 8'h00, v);
      n++;
    end
    chk("ctrl", {24'h00_0000, c}, v);
    r = vr ? (LVL[ch] >> 1) : LVL[ch];
    ph = jr ? {6'h00, r[9:8]} : r[9:2];
    pl = jr ? r[7:0] : {r[1:0], 6'h00};
    chk("chan", {30'h0, ch[1:0]}, {30'h0, chs});
    chk("ref", {31'h0, vr}, {31'h0, rext});
    if (div > 0) chk("span", 1, (last_low >= 11 * div && last_low <= 11 * div + 4));
    chk("irq", {31'h0, msk}, {31'h0, irq});
    chk_reg(IDX_FLAG, 8'h40);
    chk_reg(IDX_RESH, ph);
    chk_reg(IDX_RESL, pl);
    wr(IDX_FLAG, 8'h40);
    chk("irq clr", 0, {31'h0, irq});
  endtask
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0000_0000;
    msk = 1'b0;
    low_n = 0;
    last_low = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_reg(IDX_CTRL, 8'h00);
    chk_reg(IDX_ANALOG_SELECT_REG, 8'h0F);
    chk_reg(IDX_DIR, 8'h0F);
    chk_reg(6'h3F, 8'h00);
    wr(IDX_CTRL, 8'hB3);
    chk_reg(IDX_CTRL, 8'h81);
    wr(IDX_ANALOG_SELECT_REG, 8'h05);
    chk("dig", 4'h5, did);
    wr(IDX_DIR, 8'h0A);
    chk("tris", 4'hA, tri_s);
    // /2 is under the minimum period: full-scale level there
    for (int i = 0; i < 6; i++) convert(cs_tab[i], (i + 2) % 4, i[0], i[1], 1 << (i + 1));
    convert(3'b011, 2, 1'b1, 1'b0, 0);
    wr(IDX_MASK, 8'h40);
    msk = 1'b1;
    convert(3'b111, 3, 1'b0, 1'b0, 0);
    wr(IDX_ANALOG_SELECT_REG, {1'b0, CS_DIV64, 4'hF});
    wr(IDX_CTRL, 8'h03);
    repeat (100) @(posedge clk);
    wr(IDX_CTRL, 8'h01);
    chk("hold", 0, {31'h0, sh});
    repeat (100) @(posedge clk);
    chk("hold", 0, {31'h0, sh});
    repeat (60) @(posedge clk);
    chk("acq", 1, {31'h0, sh});
    chk_reg(IDX_RESH, ph);
    chk_reg(IDX_RESL, pl);
    chk_reg(IDX_FLAG, 8'h00);
    wr(IDX_CTRL, 8'h83);
    repeat (50) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("on", 0, {31'h0, on});
    chk_reg(IDX_CTRL, 8'h00);
    chk_reg(IDX_RESH, ph);
    chk_reg(IDX_RESL, pl);
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule // sar_adc_sequencer_bench
`default_nettype wire
